/* rtl/adc_compute_pkg.sv */
// Functional notes
// - Mode field: 000 basic, 001 accumulate, 010 average, 011 burst, 100 filter.
// - Accumulator clear command self-clears once the clearing has finished.
// - Single-sample error formula chosen by the formula selector.
// - Double-sample codes 010/001 subtract filter/setpoint from result minus previous.
// - Double-sample with previous source zero computes error every second sample.
// - Continuous with stop-on-threshold clears start on hit, else retriggers.
// - Threshold interrupt raised per the 3-bit selector comparisons.
// - Overflow flag bit 7 set on accumulator, filter or error overflow.
// - Status bit 6 shows error above upper threshold.
// - Status bit 5 shows error below lower threshold.
// - Computation flag bit 4 set by hardware on updates, cleared by software.
// - Software clear of computation flag ignored while stage reads 100.
// - Stage field reports idle, first and second phases, and suspension.
// - Suspended code shown between triggers with double-sample, not continuous.
// - Converter clock is system clock divided by 2*(n+1).
// - Divider only used when system clock is the converter clock source.
// - Negative reference select bit 4: 1 external pin, 0 analog ground.
// - Clock source bit 1 picks dedicated oscillator, 0 divided system clock.
// - Double-sample pairs conversions, computing after every second one.
`default_nettype none
package adc_compute_pkg;
    localparam int ADDR_W = 18;
    // Printed offsets are register indices; byte address is four times them
    localparam logic [15:0] IDX_CTRL = 16'h1D28;
    localparam logic [15:0] IDX_ERR_CTRL = 16'h1D29;
    localparam logic [15:0] IDX_STATUS = 16'h1D2A;
    localparam logic [15:0] IDX_REF = 16'h1D2B;
    localparam logic [15:0] IDX_CLKDIV = 16'h1D2D;
    localparam logic [15:0] IDX_THRESH = 16'h1D2E;
    localparam logic [15:0] IDX_SETPT = 16'h1D2F;
    localparam logic [15:0] IDX_VALUES = 16'h1D30;
    localparam logic [7:0] ERR_CTRL_RST = 8'h00;
    localparam logic [7:0] REF_RST = 8'h00;
    localparam logic [5:0] CLKDIV_RST = 6'h00;
    localparam int ST_OVF = 7;
    localparam int ST_ABOVE = 6;
    localparam int ST_BELOW = 5;
    localparam int ST_COMPUTATION_DONE_FLAG = 4;
    localparam int REF_NEG = 4;
    localparam logic [2:0] STAGE_IDLE = 3'h0;
    localparam logic [2:0] STAGE_SUSP = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_BASIC = 3'h0, MODE_ACCUM = 3'h1, MODE_AVG = 3'h2,
        MODE_BURST = 3'h3, MODE_LPF = 3'h4
    } op_mode_t;

    typedef struct packed {
        logic [7:0] repeat_target;
        logic [3:0] spare;
        logic clk_source;
        logic conv_start;
        logic repeat_conversion;
        logic double_sample_en;
        logic prev_source_sel;
        logic [2:0] shift_select;
        logic accum_clear_cmd;
        logic [2:0] operating_mode;
    } ctrl_t;

    typedef struct packed {
        logic valid;
        logic [15:0] conv_result;
    } core_result_t;
endpackage : adc_compute_pkg
`default_nettype wire

/* rtl/adc_compute_ctrl.sv */
`default_nettype none
module adc_compute_ctrl
    import adc_compute_pkg::*;
#(
    parameter int ACC_W = 24
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire core_result_t core_in,
    input wire logic [1:0] core_phase,
    input wire logic rc_osc,
    output logic start_conv,
    output logic threshold_event,
    output logic conv_clk,
    output logic neg_ref_ext
);
    localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_ERRC = {IDX_ERR_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT = {IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] A_REF = {IDX_REF, 2'b00};
    localparam logic [ADDR_W-1:0] A_CDIV = {IDX_CLKDIV, 2'b00};
    localparam logic [ADDR_W-1:0] A_THR = {IDX_THRESH, 2'b00};
    localparam logic [ADDR_W-1:0] A_SETP = {IDX_SETPT, 2'b00};
    localparam logic [ADDR_W-1:0] A_VAL = {IDX_VALUES, 2'b00};

    ctrl_t ctrl_ff;
    logic [7:0] errc_ff, ref_ff;
    logic [5:0] cdiv_ff;
    logic [15:0] upper_ff, lower_ff, setpoint_ff;
    logic aw_got_ff, w_got_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_fire, wr_hit;
    logic [31:0] nxt_rdata;
    logic rd_hit;

    logic signed [ACC_W-1:0] acc_ff;
    logic [7:0] cnt_ff;
    logic signed [15:0] filter_ff, result_ff, prev_ff, error_ff;
    logic ovf_ff, above_ff, below_ff, computation_done_flag_ff;
    logic second_ff, pair_done_ff, error_formula_sel_ff, busy_ff;
    logic [2:0] stage;
    logic ovf_set, computation_done_flag_set, do_err, hit;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    // Write address and data are taken in either order, then committed
    assign awready = !aw_got_ff && !bvalid;
    assign wready = !w_got_ff && !bvalid;
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end else if (wr_fire) begin
                aw_got_ff <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end else if (wr_fire) begin
                w_got_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (awaddr_ff)
            A_CTRL, A_ERRC, A_STAT, A_REF, A_CDIV, A_THR, A_SETP, A_VAL:
                wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        nxt_rdata = '0;
        unique case (araddr)
            A_CTRL: nxt_rdata = {8'h00, ctrl_ff};
            A_ERRC: nxt_rdata = {24'h0, errc_ff};
            A_STAT: nxt_rdata = {24'h0, ovf_ff, above_ff, below_ff,
                                 computation_done_flag_ff, 1'b0, stage};
            A_REF: nxt_rdata = {24'h0, ref_ff};
            A_CDIV: nxt_rdata = {26'h0, cdiv_ff};
            A_THR: nxt_rdata = {lower_ff, upper_ff};
            A_SETP: nxt_rdata = {16'h0, setpoint_ff};
            A_VAL: nxt_rdata = {filter_ff, error_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= nxt_rdata;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Plain software registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            errc_ff <= ERR_CTRL_RST;
            ref_ff <= REF_RST;
            cdiv_ff <= CLKDIV_RST;
            upper_ff <= '0;
            lower_ff <= '0;
            setpoint_ff <= '0;
        end else if (wr_fire) begin
            if (awaddr_ff == A_ERRC && wstrb_ff[0]) begin
                errc_ff <= {1'b0, wdata_ff[6:0]};
            end
            if (awaddr_ff == A_REF && wstrb_ff[0]) begin
                ref_ff <= {3'h0, wdata_ff[4], 2'h0, wdata_ff[1:0]};
            end
            if (awaddr_ff == A_CDIV && wstrb_ff[0]) begin
                cdiv_ff <= wdata_ff[5:0];
            end
            if (awaddr_ff == A_THR) begin
                {lower_ff, upper_ff} <= merge({lower_ff, upper_ff},
                                              wdata_ff, wstrb_ff);
            end
            if (awaddr_ff == A_SETP) begin
                setpoint_ff <= 16'(merge({16'h0, setpoint_ff}, wdata_ff,
                                         wstrb_ff));
            end
        end
    end
    assign neg_ref_ext = ref_ff[REF_NEG];

    // Control: software write wins over the hardware clears of the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_ff <= '0;
        end else if (wr_fire && awaddr_ff == A_CTRL) begin
            ctrl_ff <= ctrl_t'(24'(merge({8'h00, ctrl_ff}, wdata_ff,
                                         wstrb_ff)));
        end else begin
            if (ctrl_ff.accum_clear_cmd) begin
                ctrl_ff.accum_clear_cmd <= 1'b0;
            end
            if (error_formula_sel_ff && (!ctrl_ff.repeat_conversion ||
                            (errc_ff[3] && hit))) begin
                ctrl_ff.conv_start <= 1'b0;
            end
        end
    end

    // Conversion sequencing toward the analog core
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            start_conv <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            start_conv <= ctrl_ff.conv_start && !busy_ff && !start_conv &&
                          !error_formula_sel_ff && core_phase == 2'b00;
            if (start_conv) begin
                busy_ff <= 1'b1;
            end else if (error_formula_sel_ff) begin
                busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            second_ff <= 1'b0;
            pair_done_ff <= 1'b0;
            error_formula_sel_ff <= 1'b0;
            result_ff <= '0;
            prev_ff <= '0;
        end else begin
            error_formula_sel_ff <= core_in.valid;
            if (start_conv) begin
                prev_ff <= ctrl_ff.prev_source_sel ? filter_ff : result_ff;
            end
            if (core_in.valid) begin
                result_ff <= core_in.conv_result;
                pair_done_ff <= !ctrl_ff.double_sample_en || second_ff;
                second_ff <= ctrl_ff.double_sample_en && !second_ff;
            end
        end
    end

    always_comb begin
        if (core_phase == 2'b00) begin
            stage = (ctrl_ff.double_sample_en && second_ff &&
                     !ctrl_ff.repeat_conversion) ? STAGE_SUSP : STAGE_IDLE;
        end else begin
            stage = {second_ff, core_phase};
        end
    end

    // Accumulator and filter; the filter always reads acc shifted right
    logic signed [ACC_W:0] acc_sum, lpf_sum;
    logic signed [ACC_W-1:0] acc_shr;
    logic at_target, acc_ovf, flt_ovf;
    always_comb begin
        acc_sum = (ACC_W+1)'(acc_ff) + (ACC_W+1)'(signed'(core_in.conv_result));
        lpf_sum = acc_sum - (ACC_W+1)'(acc_ff >>> ctrl_ff.shift_select);
        acc_shr = ACC_W'((ctrl_ff.operating_mode == MODE_LPF ? lpf_sum
                          : acc_sum) >>> ctrl_ff.shift_select);
        at_target = (cnt_ff + 8'h01) >= ctrl_ff.repeat_target;
        acc_ovf = (acc_sum[ACC_W] != acc_sum[ACC_W-1]) ||
                  (lpf_sum[ACC_W] != lpf_sum[ACC_W-1]);
        flt_ovf = acc_shr != ACC_W'(signed'(acc_shr[15:0]));
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_ff <= '0;
            cnt_ff <= '0;
            filter_ff <= '0;
        end else if (ctrl_ff.accum_clear_cmd) begin
            acc_ff <= '0;
            cnt_ff <= '0;
        end else if (core_in.valid) begin
            unique case (ctrl_ff.operating_mode)
                MODE_ACCUM: begin
                    acc_ff <= acc_sum[ACC_W-1:0];
                    cnt_ff <= (cnt_ff == 8'hFF) ? cnt_ff : cnt_ff + 8'h01;
                    filter_ff <= acc_shr[15:0];
                end
                MODE_AVG, MODE_BURST: begin
                    acc_ff <= at_target ? '0 : acc_sum[ACC_W-1:0];
                    cnt_ff <= at_target ? 8'h00 : cnt_ff + 8'h01;
                    if (at_target) begin
                        filter_ff <= acc_shr[15:0];
                    end
                end
                MODE_LPF: begin
                    acc_ff <= lpf_sum[ACC_W-1:0];
                    filter_ff <= acc_shr[15:0];
                end
                default: ;
            endcase
        end
    end

    // Error value and threshold tests
    logic signed [17:0] e_error_formula_sel;
    logic e_ovf, e_above, e_below;
    always_comb begin
        e_error_formula_sel = '0;
        unique case (errc_ff[6:4])
            3'h5: e_error_formula_sel = 18'(filter_ff) - 18'(setpoint_ff);
            3'h4: e_error_formula_sel = 18'(prev_ff) - 18'(filter_ff);
            3'h2: e_error_formula_sel = ctrl_ff.double_sample_en
                  ? 18'(result_ff) - 18'(prev_ff) - 18'(filter_ff)
                  : 18'(result_ff) - 18'(filter_ff);
            3'h1: e_error_formula_sel = ctrl_ff.double_sample_en
                  ? 18'(result_ff) - 18'(prev_ff) - 18'(setpoint_ff)
                  : 18'(result_ff) - 18'(setpoint_ff);
            3'h0: e_error_formula_sel = 18'(result_ff) - 18'(prev_ff);
            default: e_error_formula_sel = '0;
        endcase
        e_ovf = e_error_formula_sel != 18'(signed'(e_error_formula_sel[15:0]));
        e_above = signed'(e_error_formula_sel[15:0]) > signed'(upper_ff);
        e_below = signed'(e_error_formula_sel[15:0]) < signed'(lower_ff);
        unique case (errc_ff[2:0])
            3'h7: hit = 1'b1;
            3'h6: hit = e_above;
            3'h5: hit = !e_above;
            3'h4: hit = e_above || e_below;
            3'h3: hit = signed'(e_error_formula_sel[15:0]) > signed'(lower_ff) &&
                        signed'(e_error_formula_sel[15:0]) < signed'(upper_ff);
            3'h2: hit = !e_below;
            3'h1: hit = e_below;
            default: hit = 1'b0;
        endcase
    end

    assign do_err = error_formula_sel_ff && pair_done_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            error_ff <= '0;
            above_ff <= 1'b0;
            below_ff <= 1'b0;
            threshold_event <= 1'b0;
        end else begin
            threshold_event <= do_err && hit;
            if (do_err) begin
                error_ff <= e_error_formula_sel[15:0];
                above_ff <= e_above;
                below_ff <= e_below;
            end
        end
    end

    // Sticky flags: a hardware set wins over a software clear
    assign ovf_set = (core_in.valid && !ctrl_ff.accum_clear_cmd &&
                      ctrl_ff.operating_mode != MODE_BASIC &&
                      (acc_ovf || flt_ovf)) || (do_err && e_ovf);
    assign computation_done_flag_set = do_err || ovf_set || (core_in.valid &&
                      ctrl_ff.operating_mode != MODE_BASIC);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ovf_ff <= 1'b0;
            computation_done_flag_ff <= 1'b0;
        end else begin
            if (ovf_set) begin
                ovf_ff <= 1'b1;
            end else if (ctrl_ff.accum_clear_cmd || (wr_fire &&
                         awaddr_ff == A_STAT && wstrb_ff[0] &&
                         !wdata_ff[ST_OVF])) begin
                ovf_ff <= 1'b0;
            end
            if (computation_done_flag_set) begin
                computation_done_flag_ff <= 1'b1;
            end else if (wr_fire && awaddr_ff == A_STAT && wstrb_ff[0] &&
                         !wdata_ff[ST_COMPUTATION_DONE_FLAG] && stage != STAGE_SUSP) begin
                computation_done_flag_ff <= 1'b0;
            end
        end
    end

    // Converter clock: divided system clock or resynchronised oscillator
    logic rc_s1_ff, rc_s2_ff, div_clk_ff;
    logic [5:0] div_cnt_ff;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rc_s1_ff <= 1'b0;
            rc_s2_ff <= 1'b0;
            div_cnt_ff <= '0;
            div_clk_ff <= 1'b0;
            conv_clk <= 1'b0;
        end else begin
            rc_s1_ff <= rc_osc;
            rc_s2_ff <= rc_s1_ff;
            if (div_cnt_ff >= cdiv_ff) begin
                div_cnt_ff <= '0;
                div_clk_ff <= !div_clk_ff;
            end else begin
                div_cnt_ff <= div_cnt_ff + 6'h01;
            end
            conv_clk <= ctrl_ff.clk_source ? rc_s2_ff : div_clk_ff;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    accum_clear_cmd_self_clear_a: assert property (
        ctrl_ff.accum_clear_cmd && !(wr_fire && awaddr_ff == A_CTRL)
        |=> !ctrl_ff.accum_clear_cmd && acc_ff == '0 && cnt_ff == '0)
        else $error("accumulator clear did not finish");
    stop_on_hit_a: assert property (
        error_formula_sel_ff && ctrl_ff.repeat_conversion && errc_ff[3] && hit &&
        !(wr_fire && awaddr_ff == A_CTRL) |=> !ctrl_ff.conv_start)
        else $error("start bit not cleared on threshold hit");
    retrigger_a: assert property (
        error_formula_sel_ff && ctrl_ff.repeat_conversion && !errc_ff[3] &&
        ctrl_ff.conv_start && !(wr_fire && awaddr_ff == A_CTRL)
        |=> ctrl_ff.conv_start)
        else $error("continuous start bit dropped");
    thresh_pulse_a: assert property (
        threshold_event |-> $past(do_err) && $past(hit))
        else $error("threshold event without cause");
    flags_follow_a: assert property (
        do_err |=> above_ff == (error_ff > signed'(upper_ff)) &&
                   below_ff == (error_ff < signed'(lower_ff)))
        else $error("threshold flags disagree with error");
    ovf_sticky_a: assert property (
        ovf_set |=> ovf_ff)
        else $error("overflow flag not set");
    computation_done_flag_hold_a: assert property (
        computation_done_flag_ff && stage == STAGE_SUSP && !computation_done_flag_set |=> computation_done_flag_ff)
        else $error("computation flag cleared while suspended");
    pair_skip_a: assert property (
        ctrl_ff.double_sample_en && core_in.valid && !second_ff
        |=> !do_err ##1 $stable(error_ff))
        else $error("error computed after first sample of pair");
    susp_stage_a: assert property (
        core_phase == 2'b00 && ctrl_ff.double_sample_en && second_ff &&
        !ctrl_ff.repeat_conversion |-> stage == STAGE_SUSP)
        else $error("suspended stage not reported");
    div_period_a: assert property (
        $changed(div_clk_ff) && $stable(cdiv_ff) && cdiv_ff == 6'h01
        |-> ##2 $changed(div_clk_ff))
        else $error("divider half period wrong");
endmodule : adc_compute_ctrl
`default_nettype wire

/* testbench/adc_core_model.sv */
`default_nettype none
module adc_core_model
    import adc_compute_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start_conv,
    input wire logic [15:0] result,
    output core_result_t core_in,
    output logic [1:0] core_phase
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] step_ff;
    // Steps 1..3 walk precharge, acquisition, conversion; step 4 delivers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            step_ff <= 3'h0;
        end else if (step_ff == 3'h4) begin
            step_ff <= 3'h0;
        end else if (step_ff != 3'h0 || start_conv) begin
            step_ff <= step_ff + 3'h1;
        end
    end
    assign core_phase = (step_ff < 3'h4) ? step_ff[1:0] : 2'h0;
    assign core_in.valid = (step_ff == 3'h4);
    // Outside the pulse the data lines show no stale value
    assign core_in.conv_result = core_in.valid ? result : ~result;
endmodule : adc_core_model
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
    import adc_compute_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, sys_rst = 1, rc_osc = 0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata, seen;
    logic [3:0] wstrb = '0, ev_cnt = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, core_phase, resp;
    logic start_conv, threshold_event, conv_clk, neg_ref_ext;
    logic [15:0] result = 16'h00C8;
    core_result_t core_in;
    int bad_count = 0, cmp_count = 0, cycles = 0;
    adc_compute_ctrl adc_compute_ctrl_i (.clock(clock), .sys_rst(sys_rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .core_in(core_in),
        .core_phase(core_phase), .rc_osc(rc_osc), .start_conv(start_conv),
        .threshold_event(threshold_event), .conv_clk(conv_clk),
        .neg_ref_ext(neg_ref_ext));
    adc_core_model adc_core_model_i (.clock(clock), .sys_rst(sys_rst),
        .start_conv(start_conv), .result(result), .core_in(core_in),
        .core_phase(core_phase));
    always #12.5 clock = ~clock;
    // Free-running oscillator, 14 system clocks per period, own phase
    initial #3 forever #175 rc_osc = ~rc_osc;
    always @(posedge clock) begin
        cycles++;
        if (threshold_event === 1'b1) ev_cnt <= ev_cnt + 4'h1;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic a, w, b;
        a = 0;
        w = 0;
        b = 0;
        @(posedge clock);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!b) begin
            @(negedge clock);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            @(posedge clock);
            if (a) awvalid <= 0;
            if (w) wvalid <= 0;
        end
        resp = bresp;
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [15:0] idx);
        logic a, r;
        a = 0;
        r = 0;
        @(posedge clock);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        while (!r) begin
            @(negedge clock);
            a = arvalid && arready;
            r = rvalid;
            seen = rdata;
            resp = rresp;
            @(posedge clock);
            if (a) arvalid <= 0;
        end
        rready <= 0;
    endtask : rd
    task automatic period(output int p);
        int rises, guard;
        logic last;
        rises = 0;
        guard = 0;
        p = 0;
        last = conv_clk;
        while (rises < 2 && guard < 200) begin
            @(negedge clock);
            guard++;
            if (rises == 1) p++;
            if (conv_clk && !last) rises++;
            last = conv_clk;
        end
    endtask : period
    task automatic reset_values();
        logic [15:0] idx[4] = '{IDX_ERR_CTRL, IDX_STATUS, IDX_REF, IDX_CLKDIV};
        foreach (idx[i]) begin
            rd(idx[i]);
            chk(seen, 32'h0, "reset value");
        end
        rd(16'h1D2C);
        chk({resp, seen}, {RESP_SLVERR, 32'h0}, "unmapped read");
    endtask : reset_values
    task automatic clock_and_ref();
        int p;
        wr(IDX_REF, 32'h10);
        chk(neg_ref_ext, 1'b1, "neg ref external");
        wr(IDX_CLKDIV, 32'h2);
        period(p);
        chk(p, 32'd6, "divided clock period");
        wr(IDX_CTRL, 32'h800);
        // First rise may come from the switch-over, not the oscillator
        period(p);
        period(p);
        chk(p, 32'd14, "oscillator clock");
        wr(IDX_CTRL, 32'h0);
    endtask : clock_and_ref
    task automatic one_conv(input logic [31:0] c);
        int guard;
        wr(IDX_CTRL, c);
        guard = 0;
        while (core_in.valid !== 1'b1 && guard < 100) begin
            @(negedge clock);
            guard++;
        end
        repeat (4) @(negedge clock);
    endtask : one_conv
    task automatic threshold_modes();
        logic [7:0] hit = 8'b1101_0100;
        logic [3:0] ev0;
        wr(IDX_SETPT, 32'h64);
        wr(IDX_THRESH, 32'h000A_0032);
        for (int c = 0; c < 8; c++) begin
            ev0 = ev_cnt;
            wr(IDX_ERR_CTRL, 32'h10 | c);
            one_conv(32'h410);
            chk(4'(ev_cnt - ev0), {3'h0, hit[c]}, "threshold event");
            rd(IDX_VALUES);
            chk(seen[15:0], 16'h0064, "result minus setpoint");
            rd(IDX_CTRL);
            chk(seen[10], 1'b0, "start cleared in single run");
        end
        rd(IDX_STATUS);
        chk(seen[7:0], 8'h50, "flags after compute");
        wr(IDX_STATUS, 32'h0);
        rd(IDX_STATUS);
        chk(seen[7:0], 8'h40, "computation flag cleared");
    endtask : threshold_modes
    task automatic average_mode();
        one_conv(32'h0002_0412);
        one_conv(32'h0002_0412);
        rd(IDX_VALUES);
        chk(seen[31:16], 16'h00C8, "average of two samples");
    endtask : average_mode
    task automatic double_sample();
        one_conv(32'h500);
        wr(IDX_STATUS, 32'h0);
        rd(IDX_STATUS);
        chk(seen[7:0], 8'h54, "suspended, flag kept");
        one_conv(32'h500);
        rd(IDX_VALUES);
        chk(seen[15:0], 16'hFF9C, "pair difference");
        rd(IDX_STATUS);
        chk(seen[7:0], 8'h30, "flags after pair");
    endtask : double_sample
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 0;
        reset_values();
        clock_and_ref();
        threshold_modes();
        average_mode();
        double_sample();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
